/* pgd_pin_interface.sv */
// Pin-level core of the pager decoder: clock source, divided clock,
// symbol clock, start-up ready timing, SPI slave and receiver lines.
// Assumes ref_clk is 10 MHz; every pin input is asynchronous to it.
`timescale 1ns/100ps
`include "pgd_params.svh"

// Summary of operation
// - Divided clock output is oscillator over two
// - Bypass select chooses crystal or external clock
// - Symbol clock marks symbol changes, core synchronous
// - Low reset initialises and holds all state
// - Symbol msb and lsb form two-bit symbol
// - Serial clock edges ignored while not selected
// - Slave takes part only while selected
// - Always slave; shift in and out together
// - Data out driven in transfers, off in reset
// - Ready high in reset, low when accepting
// - Eight receiver lines, released during reset
// - Ready low exactly 76800 oscillator periods after reset
// - Ready high within 200 ns of reset
module pgd_pin_interface #(
    parameter int READY_DELAY = `PGD_READY_DELAY_T,
    parameter int PKT_BITS    = `PGD_PKT_BITS
) (
    input  wire logic                          ref_clk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    input  wire logic                          oscillator_input,
    input  wire logic                          oscillator_bypass_select,
    input  wire pgd_pkg::pgd_symbol_type       symbol_in,
    input  wire pgd_pkg::pgd_spi_in_type       spi_in,
    output logic                               oscillator_output,
    output logic                               divided_clock_output,
    output logic                               recovered_symbol_clock,
    output pgd_pkg::pgd_spi_out_type           spi_out,
    output logic                               spi_ready,
    output logic [`PGD_RX_CTRL_BITS-1:0]       receiver_control_lines,
    output logic                               receiver_control_oe
);

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam int READY_HIGH_CYC =
        (`PGD_READY_HIGH_NS + `PGD_CLK_PERIOD_NS - 1) / `PGD_CLK_PERIOD_NS;
    localparam int SYM_HIGH_CYC =
        (`PGD_RECOVERED_SYMBOL_CLOCK_HIGH_NS + `PGD_CLK_PERIOD_NS - 1) / `PGD_CLK_PERIOD_NS;
    localparam int INIT_W = $clog2(READY_DELAY + 1);
    localparam int BUSY_W = $clog2(READY_HIGH_CYC + 1);
    localparam int SYMW   = $clog2(SYM_HIGH_CYC + 1);
    localparam int BITW   = $clog2(PKT_BITS + 1);
    localparam int NB     = `PGD_SYNC_BITS;
    localparam int NC     = `PGD_RX_CTRL_BITS;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [NB-1:0] pins_raw;
    logic [NB-1:0] sync1_q;
    logic [NB-1:0] sync2_q;
    logic [NB-1:0] prev_q;

    assign pins_raw[`PGD_PIN_OSC]     = oscillator_input;
    assign pins_raw[`PGD_PIN_BYPASS]  = oscillator_bypass_select;
    assign pins_raw[`PGD_PIN_SYM_LSB] = symbol_in.lsb;
    assign pins_raw[`PGD_PIN_SYM_MSB] = symbol_in.msb;
    assign pins_raw[`PGD_PIN_SCK]     = spi_in.sck;
    assign pins_raw[`PGD_PIN_SS_N]    = spi_in.ss_n;
    assign pins_raw[`PGD_PIN_MOSI]    = spi_in.mosi;

    localparam logic [NB-1:0] SYNC_RV = NB'(`PGD_SYNC_RST);

    // Two flops per pin; the third stage only serves edge detection
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_sync
            localparam logic RV = SYNC_RV[gi];
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    sync1_q[gi] <= RV;
                    sync2_q[gi] <= RV;
                    prev_q[gi]  <= RV;
                end else if (ce) begin
                    sync1_q[gi] <= pins_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi]  <= sync2_q[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Decoded pin events
    // ****************************************************************
    logic       osc_rise;
    logic       bypass;
    logic [1:0] sym_now;
    logic [1:0] sym_prev;
    logic       sel;
    logic       sel_start;
    logic       sck_rise;
    logic       sck_fall;

    always_comb begin
        osc_rise  = sync2_q[`PGD_PIN_OSC] & ~prev_q[`PGD_PIN_OSC];
        bypass    = sync2_q[`PGD_PIN_BYPASS];
        sym_now   = {sync2_q[`PGD_PIN_SYM_MSB],
                     sync2_q[`PGD_PIN_SYM_LSB]};
        sym_prev  = {prev_q[`PGD_PIN_SYM_MSB],
                     prev_q[`PGD_PIN_SYM_LSB]};
        sel       = ~sync2_q[`PGD_PIN_SS_N];
        sel_start = sel & prev_q[`PGD_PIN_SS_N];
        sck_rise  = sync2_q[`PGD_PIN_SCK] & ~prev_q[`PGD_PIN_SCK];
        sck_fall  = ~sync2_q[`PGD_PIN_SCK] & prev_q[`PGD_PIN_SCK];
    end

    // ****************************************************************
    // Serial slave
    // ****************************************************************
    logic [PKT_BITS-1:0] rx_q, rx_d;
    logic [PKT_BITS-1:0] tx_q, tx_d;
    logic [BITW-1:0]     bit_q, bit_d;
    logic                miso_q, miso_d;
    logic                miso_oe_q, miso_oe_d;
    logic [NC-1:0]       ctrl_q, ctrl_d;
    logic                ctrl_oe_q, ctrl_oe_d;
    logic                pkt_done;
    logic [NC-1:0]       pkt_low;

    always_comb begin
        rx_d      = rx_q;
        tx_d      = tx_q;
        bit_d     = bit_q;
        ctrl_d    = ctrl_q;
        ctrl_oe_d = 1'b1;
        pkt_done  = 1'b0;
        if (sel_start) begin
            // Reply word: current symbol and receiver line state
            tx_d  = PKT_BITS'({sym_now, ctrl_q});
            bit_d = '0;
        end else if (sel && sck_rise) begin
            rx_d = {rx_q[PKT_BITS-2:0],
                    sync2_q[`PGD_PIN_MOSI]};
            if (bit_q == BITW'(PKT_BITS - 1)) begin
                bit_d    = '0;
                pkt_done = 1'b1;
            end else begin
                bit_d = bit_q + 1'b1;
            end
        end else if (sel && sck_fall) begin
            tx_d = {tx_q[PKT_BITS-2:0], 1'b0};
        end
        pkt_low = rx_d[NC-1:0];
        if (pkt_done) begin
            ctrl_d = pkt_low;
        end
        miso_d    = tx_d[PKT_BITS-1];
        miso_oe_d = sel;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_q      <= '0;
            tx_q      <= '0;
            bit_q     <= '0;
            miso_q    <= 1'b0;
            miso_oe_q <= 1'b0;
            ctrl_q    <= '0;
            ctrl_oe_q <= 1'b0;
        end else if (ce) begin
            rx_q      <= rx_d;
            tx_q      <= tx_d;
            bit_q     <= bit_d;
            miso_q    <= miso_d;
            miso_oe_q <= miso_oe_d;
            ctrl_q    <= ctrl_d;
            ctrl_oe_q <= ctrl_oe_d;
        end
    end

    // ****************************************************************
    // Clocks, start-up and ready
    // ****************************************************************
    logic              osc_out_q, osc_out_d;
    logic              div_q, div_d;
    logic              init_done_q, init_done_d;
    logic [INIT_W-1:0] init_cnt_q, init_cnt_d;
    logic [BUSY_W-1:0] busy_q, busy_d;
    logic              ready_q, ready_d;
    logic [SYMW-1:0]   sym_cnt_q, sym_cnt_d;
    logic              recovered_symbol_clock_q, recovered_symbol_clock_d;

    always_comb begin
        // With the bypass strap high the feedback inverter is off
        osc_out_d   = bypass ? 1'b0 : ~sync2_q[`PGD_PIN_OSC];
        div_d       = div_q ^ osc_rise;
        init_done_d = init_done_q;
        init_cnt_d  = init_cnt_q;
        if (!init_done_q && osc_rise) begin
            if (init_cnt_q == INIT_W'(READY_DELAY - 1)) begin
                init_done_d = 1'b1;
            end else begin
                init_cnt_d = init_cnt_q + 1'b1;
            end
        end
        // A taken packet holds ready high while the core digests it
        busy_d = busy_q;
        if (pkt_done) begin
            busy_d = BUSY_W'(READY_HIGH_CYC);
        end else if (busy_q != '0) begin
            busy_d = busy_q - 1'b1;
        end
        ready_d   = !init_done_d || (busy_d != '0);
        sym_cnt_d = sym_cnt_q;
        if (sym_now != sym_prev) begin
            sym_cnt_d = SYMW'(SYM_HIGH_CYC);
        end else if (sym_cnt_q != '0) begin
            sym_cnt_d = sym_cnt_q - 1'b1;
        end
        recovered_symbol_clock_d = (sym_cnt_d != '0);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            osc_out_q   <= 1'b0;
            div_q       <= 1'b0;
            init_done_q <= 1'b0;
            init_cnt_q  <= '0;
            busy_q      <= '0;
            ready_q     <= 1'b1;
            sym_cnt_q   <= '0;
            recovered_symbol_clock_q    <= 1'b0;
        end else if (ce) begin
            osc_out_q   <= osc_out_d;
            div_q       <= div_d;
            init_done_q <= init_done_d;
            init_cnt_q  <= init_cnt_d;
            busy_q      <= busy_d;
            ready_q     <= ready_d;
            sym_cnt_q   <= sym_cnt_d;
            recovered_symbol_clock_q    <= recovered_symbol_clock_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign oscillator_output      = osc_out_q;
    assign divided_clock_output   = div_q;
    assign recovered_symbol_clock = recovered_symbol_clock_q;
    assign spi_out.miso           = miso_q;
    assign spi_out.miso_oe        = miso_oe_q;
    assign spi_ready              = ready_q;
    assign receiver_control_lines = ctrl_q;
    assign receiver_control_oe    = ctrl_oe_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_div_toggle: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && osc_rise) |=> (div_q != $past(div_q)))
        else $error("divided clock did not toggle on oscillator edge");

    a_osc_bypass_off: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && bypass) |=> !osc_out_q)
        else $error("oscillator output driven while bypassed");

    a_sym_clk_mark: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && sym_now != sym_prev) |=> recovered_symbol_clock_q)
        else $error("symbol clock missed a symbol change");

    a_ready_before_init: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !init_done_q |-> ready_q)
        else $error("ready low before start-up count ended");

    a_ready_at_count: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && osc_rise && !init_done_q && busy_q == '0 && !pkt_done
         && init_cnt_q == INIT_W'(READY_DELAY - 1)) |=> !ready_q)
        else $error("ready not low at end of start-up count");

    a_packet_busy: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && pkt_done) |=> ready_q ##1 (ready_q || !ce))
        else $error("ready not high after taken packet");

    a_sck_ignored: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && !sel && !sel_start) |=> $stable(bit_q) && $stable(rx_q))
        else $error("serial clock acted while not selected");

    a_miso_select: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ce |=> (miso_oe_q == $past(sel)))
        else $error("data out enable does not follow select");

    a_ctrl_load: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && pkt_done) |=> (ctrl_q == $past(pkt_low)) && ctrl_oe_q)
        else $error("receiver lines not loaded from packet");

    a_shift_in: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (ce && sel && sck_rise && !sel_start) |=>
        (rx_q[0] == $past(sync2_q[`PGD_PIN_MOSI])))
        else $error("serial input bit not captured");

endmodule

/* pgd_params.svh */
// Constants for the pager decoder pin interface: timing, pin slots, sizes.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PGD_PARAMS_SVH
`define PGD_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define PGD_CLK_PERIOD_NS   100
`define PGD_READY_DELAY_T   76800
`define PGD_READY_HIGH_NS   50000
`define PGD_RECOVERED_SYMBOL_CLOCK_HIGH_NS  100000

// ****************************************************************
// Sizes
// ****************************************************************
`define PGD_PKT_BITS        32
`define PGD_RX_CTRL_BITS    8
`define PGD_SYNC_BITS       7

// ****************************************************************
// Slots of the synchroniser vector
// ****************************************************************
`define PGD_PIN_OSC         0
`define PGD_PIN_BYPASS      1
`define PGD_PIN_SYM_LSB     2
`define PGD_PIN_SYM_MSB     3
`define PGD_PIN_SCK         4
`define PGD_PIN_SS_N        5
`define PGD_PIN_MOSI        6

// Slave select idles high, everything else low
`define PGD_SYNC_RST        7'h20

`endif

/* pgd_pkg.sv */
// Types shared by the pager decoder pin interface.
// Assumes pgd_params.svh is on the include path.
`include "pgd_params.svh"

package pgd_pkg;

    // ****************************************************************
    // Pin groups
    // ****************************************************************
    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
    } pgd_spi_in_type;

    typedef struct packed {
        logic miso;
        logic miso_oe;
    } pgd_spi_out_type;

    typedef struct packed {
        logic msb;
        logic lsb;
    } pgd_symbol_type;

endpackage

/* pgd_host_model.sv */
// Host microcontroller model: SPI master in mode 0, MSB first.
// Assumes ref_clk of the bench; drives pins just after each falling edge.
`timescale 1ns/100ps

// ****************************************************************
// Host model
// ****************************************************************
module pgd_host_model #(
    parameter int HALF = 6
) (
    input  wire logic                     ref_clk,
    input  wire logic                     spi_ready,
    input  wire pgd_pkg::pgd_spi_out_type spi_out,
    output pgd_pkg::pgd_spi_in_type       spi_in
);
    // Serial clock idles low, select idles high
    initial spi_in = 3'h2;

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // A half period of HALF cycles leaves the slave its pin latency
    task automatic transfer(input logic [31:0] tx, output logic [31:0] rx,
                            output logic ok);
        int i;
        ok = 1'h0;
        rx = 32'h0;
        for (i = 0; i < 2000 && spi_ready !== 1'h0; i++) begin
            wait_n(1);
        end
        if (spi_ready === 1'h0) begin
            ok = 1'h1;
        end
        spi_in.ss_n = 1'h0;
        wait_n(8);
        for (i = 31; i >= 0; i--) begin
            spi_in.mosi = tx[i];
            wait_n(HALF);
            rx = {rx[30:0], spi_out.miso_oe ? spi_out.miso : 1'hZ};
            spi_in.sck = 1'h1;
            wait_n(HALF);
            spi_in.sck = 1'h0;
        end
        wait_n(HALF);
        spi_in.ss_n = 1'h1;
        // Released data line shows the inverse of its last value
        spi_in.mosi = ~spi_in.mosi;
    endtask

    // Clocks with select high, which the slave must ignore
    task automatic idle_clocks(input int n);
        repeat (n) begin
            spi_in.sck = 1'h1;
            spi_in.mosi = ~spi_in.mosi;
            wait_n(HALF);
            spi_in.sck = 1'h0;
            wait_n(HALF);
        end
    endtask
endmodule

/* pgd_pin_interface_test.sv */
// Self-checking bench of the pager decoder pin interface.
// Assumes pgd_pkg and pgd_host_model compiled before it.
`timescale 1ns/100ps

module pgd_pin_interface_test;
    localparam int OSC_HALF = 20;

    logic                      ref_clk;
    logic                      nrst;
    logic                      ce;
    logic                      osc;
    logic                      bypass;
    pgd_pkg::pgd_symbol_type   sym;
    pgd_pkg::pgd_spi_in_type   spi_in;
    pgd_pkg::pgd_spi_out_type  spi_out;
    logic                      osc_out;
    logic                      div_clk;
    logic                      sym_clk;
    logic                      spi_ready;
    logic [7:0]                rx_lines;
    logic                      rx_oe;
    int                        n_errors;
    int                        n_tests;
    int                        cycles;

    // ****************************************************************
    // Design and host
    // ****************************************************************
    // Short start-up count keeps the run brief
    pgd_pin_interface #(.READY_DELAY(8), .PKT_BITS(32)) i_dut (
        .ref_clk                  (ref_clk),
        .nrst                     (nrst),
        .ce                       (ce),
        .oscillator_input         (osc),
        .oscillator_bypass_select (bypass),
        .symbol_in                (sym),
        .spi_in                   (spi_in),
        .oscillator_output        (osc_out),
        .divided_clock_output     (div_clk),
        .recovered_symbol_clock   (sym_clk),
        .spi_out                  (spi_out),
        .spi_ready                (spi_ready),
        .receiver_control_lines   (rx_lines),
        .receiver_control_oe      (rx_oe)
    );

    pgd_host_model #(.HALF(6)) i_host (
        .ref_clk   (ref_clk),
        .spi_ready (spi_ready),
        .spi_out   (spi_out),
        .spi_in    (spi_in)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset;
        nrst = 1'h0;
        wait_n(1);
        check(spi_ready, 1'h1);
        check(spi_out.miso_oe, 1'h0);
        check(rx_oe, 1'h0);
        check(rx_lines, 8'h00);
        wait_n(3);
        nrst = 1'h1;
        wait_n(2);
        check(rx_oe, 1'h1);
    endtask

    // Ready must stay high through seven rises and fall after the eighth
    task automatic test_startup;
        logic prev;
        int   i;
        for (i = 1; i <= 8; i++) begin
            check(spi_ready, 1'h1);
            prev = div_clk;
            osc = 1'h1;
            wait_n(6);
            check(div_clk, !prev);
            check(osc_out, 1'h0);
            wait_n(OSC_HALF - 6);
            osc = 1'h0;
            wait_n(OSC_HALF);
            check(osc_out, 1'h1);
        end
        check(spi_ready, 1'h0);
        // Oscillator low keeps the feedback output high unless bypassed
        bypass = 1'h1;
        wait_n(6);
        check(osc_out, 1'h0);
        prev = div_clk;
        osc = 1'h1;
        wait_n(6);
        check(div_clk, !prev);
        osc = 1'h0;
        bypass = 1'h0;
    endtask

    // An oscillator pulse while frozen must leave the divider alone
    task automatic test_freeze;
        logic prev;
        prev = div_clk;
        ce = 1'h0;
        osc = 1'h1;
        wait_n(10);
        check(div_clk, prev);
        osc = 1'h0;
        wait_n(2);
        ce = 1'h1;
        wait_n(6);
        check(div_clk, prev);
    endtask

    task automatic test_symbol;
        sym = 2'h2;
        wait_n(6);
        check(sym_clk, 1'h1);
        wait_n(994);
        check(sym_clk, 1'h1);
        wait_n(10);
        check(sym_clk, 1'h0);
    endtask

    // Reply carries symbol and the lines left by the previous packet
    task automatic test_spi;
        logic [31:0] rx;
        logic        ok;
        i_host.transfer(32'hA5C33C5A, rx, ok);
        check(ok, 1'h1);
        check(rx, {22'h0, 2'h2, 8'h00});
        check(rx_lines, 8'h5A);
        check(spi_ready, 1'h1);
        wait_n(6);
        check(spi_out.miso_oe, 1'h0);
        i_host.idle_clocks(40);
        check(rx_lines, 8'h5A);
        i_host.transfer(32'h000000C3, rx, ok);
        check(ok, 1'h1);
        check(rx, {22'h0, 2'h2, 8'h5A});
        check(rx_lines, 8'hC3);
        wait_n(400);
        check(spi_ready, 1'h1);
        wait_n(200);
        check(spi_ready, 1'h0);
    endtask

    // ****************************************************************
    // Main sequence and timeout
    // ****************************************************************
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        n_errors = 0;
        n_tests = 0;
        cycles = 0;
        nrst = 1'h0;
        ce = 1'h1;
        osc = 1'h0;
        bypass = 1'h0;
        sym = 2'h0;
        test_reset();
        test_startup();
        test_symbol();
        test_freeze();
        test_spi();
        test_reset();
        final_report();
    end
endmodule
